//--- pkg/six_bit_port_regs.svh
// register indices, field positions, reset values and bus constants of the six-bit port
`ifndef SIX_BIT_PORT_REGS_SVH
`define SIX_BIT_PORT_REGS_SVH

`define PORT_WIDTH 6
`define PIN_THREE 3
`define ADR_WIDTH 10

// register indices; byte address is four times the index
`define IDX_PORT_PIN_DATA 8'h05
`define IDX_INTERRUPT_CONTROL 8'h0B
`define IDX_OPTION 8'h81
`define IDX_PORT_DIRECTION 8'h85
`define IDX_ANALOG_SELECT 8'h91
`define IDX_PULLUP_ENABLE 8'h95
`define IDX_CHANGE_INT_MASK 8'h96
`define IDX_CONFIG 8'hA0

// field positions
`define BIT_GLOBAL_PULLUP_DISABLE 7
`define BIT_PORT_CHANGE_FLAG 0
`define BIT_PORT_CHANGE_INT_ENABLE 3
`define BIT_RESET_PIN_ENABLE 0

// reset values
`define RST_DIRECTION 6'h3F
`define RST_OPTION 8'hFF
`define RST_ANALOG_SELECT 8'hFF
`define RST_PULLUP_ENABLE 6'h00
`define RST_CHANGE_INT_MASK 6'h00
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_CONFIG 1'h0
`define RST_OUT_LATCH 6'h00

`endif

//--- pkg/six_bit_port_pkg.sv
// types shared by the six-bit port design
`default_nettype none
package six_bit_port_pkg;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic [5:0] enable;
        logic [5:0] drive;
        logic [5:0] oe;
    } periph_ctl_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;
endpackage
`default_nettype wire

//--- logic/pin_sync.sv
// two-stage synchroniser for the six pin levels
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [5:0] pin_i,
    output logic [5:0] pin_sync_o
);
    logic [5:0] stage_one;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_one <= 6'h00;
            pin_sync_o <= 6'h00;
        end else begin
            stage_one <= pin_i;
            pin_sync_o <= stage_one;
        end
    end
endmodule // pin_sync
`default_nettype wire

//--- logic/change_detect.sv
// interrupt-on-change comparator against the level latched at the last data read
`timescale 1ns/1ns
`default_nettype none
module change_detect (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [5:0] level_i,
    input wire logic [5:0] watch_i,
    input wire logic read_i,
    output logic mismatch_o
);
    logic [5:0] last_read;

    // snapshot taken when software reads the data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_read <= 6'h00;
        end else if (read_i) begin
            last_read <= level_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mismatch_o <= 1'b0;
        end else begin
            mismatch_o <= |((level_i ^ last_read) & watch_i);
        end
    end
endmodule // change_detect
`default_nettype wire

//--- logic/six_bit_bidir_port.sv
// six-bit bidirectional port with pull-ups and change detection, wishbone slave
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "six_bit_port_regs.svh"
module six_bit_bidir_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire six_bit_port_pkg::wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [5:0] pin_i,
    output logic [5:0] pin_out_o,
    output logic [5:0] pin_oe_o,
    output logic [5:0] pin_pullup_o,
    input wire six_bit_port_pkg::periph_ctl_t periph_i,
    output logic [5:0] periph_pin_o,
    output logic port_change_irq_o
);
    import six_bit_port_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // analog channels land on pins 0, 1, 2 and 4
    function automatic logic [5:0] analog_pins(input logic [7:0] sel);
        analog_pins = {1'b0, sel[3], 1'b0, sel[2], sel[1], sel[0]};
    endfunction

    function automatic logic [7:0] index_of(input logic [9:0] adr);
        index_of = adr[9:2];
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old_val, input logic [7:0] new_val,
                                              input logic lane);
        merge_byte = lane ? new_val : old_val;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bus_state_t bus_state;
    logic [5:0] out_latch;
    logic [5:0] direction;
    logic [5:0] pullup_enable;
    logic [5:0] change_interrupt_mask;
    logic [7:0] analog_select;
    logic [7:0] option_reg;
    logic [7:0] interrupt_control_reg;
    logic reset_pin_enable_config;
    logic [5:0] level_sync;
    logic change_seen;

    logic [7:0] idx;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;
    logic [7:0] next_latch_byte;
    logic [5:0] analog_mask;
    logic [5:0] pin_read;
    logic [5:0] dir_view;
    logic [5:0] watch;
    logic [7:0] read_mux;

    assign idx = index_of(wb_req_i.adr);
    assign wbyte = wb_req_i.dat[7:0];
    // a transfer completes on the edge where ack is high
    assign wr_fire = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & (bus_state == BUS_ACK);
    assign rd_fire = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & (bus_state == BUS_ACK);
    assign analog_mask = analog_pins(analog_select);
    assign next_latch_byte = merge_byte({2'b00, pin_read}, wbyte, wb_req_i.sel[0]);

    // ------------------------------------------------------------
    // pin input path
    // ------------------------------------------------------------
    pin_sync u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_i),
        .pin_sync_o(level_sync)
    );

    always_comb begin
        pin_read = level_sync;
        pin_read = pin_read & ~analog_mask;
        pin_read = pin_read & ~periph_i.enable;
        if (reset_pin_enable_config) begin
            pin_read[`PIN_THREE] = 1'b0;
        end
    end

    always_comb begin
        dir_view = direction;
        dir_view[`PIN_THREE] = 1'b1;
    end

    // analog pins and pin three as reset input lose change detection
    always_comb begin
        watch = change_interrupt_mask & ~analog_mask & ~periph_i.enable;
        if (reset_pin_enable_config) begin
            watch[`PIN_THREE] = 1'b0;
        end
    end

    change_detect u_change_detect (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(level_sync),
        .watch_i(watch),
        .read_i(rd_fire && idx == `IDX_PORT_PIN_DATA),
        .mismatch_o(change_seen)
    );

    // ------------------------------------------------------------
    // wishbone handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state <= BUS_IDLE;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (wb_req_i.cyc && wb_req_i.stb) begin
                        bus_state <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_state <= BUS_IDLE;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= (bus_state == BUS_IDLE) && wb_req_i.cyc && wb_req_i.stb;
        end
    end

    always_comb begin
        if (idx == `IDX_PORT_PIN_DATA) begin
            read_mux = {2'b00, pin_read};
        end else if (idx == `IDX_PORT_DIRECTION) begin
            read_mux = {2'b00, dir_view};
        end else if (idx == `IDX_PULLUP_ENABLE) begin
            read_mux = {2'b00, pullup_enable};
        end else if (idx == `IDX_CHANGE_INT_MASK) begin
            read_mux = {2'b00, change_interrupt_mask};
        end else if (idx == `IDX_ANALOG_SELECT) begin
            read_mux = analog_select;
        end else if (idx == `IDX_OPTION) begin
            read_mux = option_reg;
        end else if (idx == `IDX_INTERRUPT_CONTROL) begin
            read_mux = interrupt_control_reg;
        end else if (idx == `IDX_CONFIG) begin
            read_mux = {7'h00, reset_pin_enable_config};
        end else begin
            read_mux = 8'h00;
        end
    end

    // read data captured as ack rises; unmapped indices read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_state == BUS_IDLE && wb_req_i.cyc && wb_req_i.stb) begin
            wb_dat_o <= {24'h000000, read_mux};
        end
    end

    // ------------------------------------------------------------
    // output latch
    // ------------------------------------------------------------
    // unselected lane rewrites the latch from the pins, where the other registers ignore the write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_latch <= `RST_OUT_LATCH;
        end else if (wr_fire && idx == `IDX_PORT_PIN_DATA) begin
            out_latch <= next_latch_byte[5:0];
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            direction <= `RST_DIRECTION;
        end else if (wr_fire && idx == `IDX_PORT_DIRECTION && wb_req_i.sel[0]) begin
            direction <= wbyte[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_enable <= `RST_PULLUP_ENABLE;
        end else if (wr_fire && idx == `IDX_PULLUP_ENABLE && wb_req_i.sel[0]) begin
            pullup_enable <= wbyte[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_interrupt_mask <= `RST_CHANGE_INT_MASK;
        end else if (wr_fire && idx == `IDX_CHANGE_INT_MASK && wb_req_i.sel[0]) begin
            change_interrupt_mask <= wbyte[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_select <= `RST_ANALOG_SELECT;
        end else if (wr_fire && idx == `IDX_ANALOG_SELECT && wb_req_i.sel[0]) begin
            analog_select <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            option_reg <= `RST_OPTION;
        end else if (wr_fire && idx == `IDX_OPTION && wb_req_i.sel[0]) begin
            option_reg <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_pin_enable_config <= `RST_CONFIG;
        end else if (wr_fire && idx == `IDX_CONFIG && wb_req_i.sel[0]) begin
            reset_pin_enable_config <= wbyte[`BIT_RESET_PIN_ENABLE];
        end
    end

    // flag set by a change wins over a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            interrupt_control_reg <= `RST_INTERRUPT_CONTROL;
        end else begin
            if (wr_fire && idx == `IDX_INTERRUPT_CONTROL && wb_req_i.sel[0]) begin
                interrupt_control_reg <= wbyte;
            end
            if (change_seen) begin
                interrupt_control_reg[`BIT_PORT_CHANGE_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_change_irq_o <= 1'b0;
        end else begin
            port_change_irq_o <= interrupt_control_reg[`BIT_PORT_CHANGE_FLAG] &
                                 interrupt_control_reg[`BIT_PORT_CHANGE_INT_ENABLE];
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_oe_o <= 6'h00;
            pin_out_o <= 6'h00;
        end else begin
            for (int i = 0; i < `PORT_WIDTH; i++) begin
                if (periph_i.enable[i]) begin
                    pin_oe_o[i] <= periph_i.oe[i];
                    pin_out_o[i] <= periph_i.drive[i];
                end else begin
                    pin_oe_o[i] <= ~dir_view[i];
                    pin_out_o[i] <= out_latch[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_pullup_o <= 6'h00;
        end else begin
            for (int i = 0; i < `PORT_WIDTH; i++) begin
                pin_pullup_o[i] <= pullup_enable[i] & dir_view[i] & ~analog_mask[i] & ~periph_i.enable[i] &
                                   ~option_reg[`BIT_GLOBAL_PULLUP_DISABLE] & (i != `PIN_THREE);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_pin_o <= 6'h00;
        end else begin
            periph_pin_o <= level_sync & ~analog_mask;
        end
    end
endmodule // six_bit_bidir_port
`default_nettype wire

//--- verification/six_bit_port_chk.sv
// assertions on the six-bit port's bus and pin outputs
`timescale 1ns/1ns
`default_nettype none
`include "six_bit_port_regs.svh"
module six_bit_port_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire six_bit_port_pkg::wb_req_t wb_req_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [5:0] pin_i,
    input wire logic [5:0] pin_out_o,
    input wire logic [5:0] pin_oe_o,
    input wire logic [5:0] pin_pullup_o,
    input wire six_bit_port_pkg::periph_ctl_t periph_i,
    input wire logic [5:0] periph_pin_o,
    input wire logic port_change_irq_o
);
    import six_bit_port_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_req;
    assign rd_req = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we;
    // ------------------------------------------------------------
    // bus and pin relations
    // ------------------------------------------------------------
    a_ack_after_take: assert property ($rose(wb_req_i.cyc && wb_req_i.stb) |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_holds: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data changed without ack");
    a_bus_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data bits above 7 not zero");
    a_data_top_zero: assert property (wb_ack_o && rd_req && wb_req_i.adr == {`IDX_PORT_PIN_DATA, 2'b00}
        |-> wb_dat_o[7:6] == 2'b00)
        else $error("port data bits 7-6 not zero");
    a_dir_bit_three: assert property (wb_ack_o && rd_req && wb_req_i.adr == {`IDX_PORT_DIRECTION, 2'b00}
        |-> wb_dat_o[3])
        else $error("direction bit 3 read as 0");
    a_pin3_no_drive: assert property ((!periph_i.enable[3]) [*2] |-> !pin_oe_o[3])
        else $error("pin 3 driven as output");
    a_pullup_not_out: assert property ((pin_oe_o & pin_pullup_o) == 6'h00)
        else $error("pull-up on while pin drives");
    a_pin3_no_pullup: assert property (!pin_pullup_o[3])
        else $error("pull-up on pin 3");
    a_reset_inputs: assert property (disable iff (1'b0) rst_i |=> pin_oe_o == 6'h00 && !port_change_irq_o)
        else $error("pins not inputs during reset");
    c_read: cover property (wb_ack_o && rd_req);
    c_irq: cover property ($rose(port_change_irq_o));
    c_drive: cover property (pin_oe_o != 6'h00 && pin_pullup_o != 6'h00);
endmodule // six_bit_port_chk
bind six_bit_bidir_port six_bit_port_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pin_i(pin_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .periph_i(periph_i), .periph_pin_o(periph_pin_o),
    .port_change_irq_o(port_change_irq_o));
`default_nettype wire

//--- verification/pin_board_model.sv
// board-side model of the six port pins
`timescale 1ns/1ns
`default_nettype none
module pin_board_model (
    input wire logic clk_i,
    input wire logic [5:0] drive_i,
    input wire logic [5:0] oe_i,
    input wire logic [5:0] pullup_i,
    input wire logic [5:0] ext_val_i,
    input wire logic [5:0] ext_en_i,
    output logic [5:0] pin_o
);
    logic [5:0] last = 6'h00;
    // external sources are resistive, so an enabled driver wins
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (oe_i[i]) begin
                pin_o[i] = drive_i[i];
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_val_i[i];
            end else if (pullup_i[i]) begin
                pin_o[i] = 1'b1;
            end else begin
                pin_o[i] = ~last[i];
            end
        end
    end
    // floating pin wanders every cycle
    always_ff @(posedge clk_i) begin
        last <= pin_o;
    end
endmodule // pin_board_model
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the six-bit port
`timescale 1ns/1ns
`default_nettype none
`include "six_bit_port_regs.svh"
module tb;
    import six_bit_port_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    wb_req_t req = '0;
    periph_ctl_t periph = '0;
    logic [5:0] ext_val = 6'h00;
    logic [5:0] ext_en = 6'h3F;
    logic [5:0] pin, pin_out, pin_oe, pin_pu;
    logic [5:0] periph_pin;
    logic ack, irq;
    logic [31:0] dat;
    logic [7:0] rd;
    int error_cnt = 0;
    int compares = 0;
    always #50 clk_i = ~clk_i;
    six_bit_bidir_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(dat),
        .pin_i(pin), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pin_pullup_o(pin_pu), .periph_i(periph),
        .periph_pin_o(periph_pin), .port_change_irq_o(irq));
    pin_board_model i_board (.clk_i(clk_i), .drive_i(pin_out), .oe_i(pin_oe), .pullup_i(pin_pu),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pin));
    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] sel);
        int n;
        n = 0;
        req <= {1'b1, 1'b1, we, sel, idx, 2'b00, 24'h000000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
        rd = dat[7:0];
        req <= '0;
        @(posedge clk_i);
    endtask
    // one more edge so registered pin outputs show the write
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd, 4'hF);
        tick(1);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string name);
        bus(1'b0, idx, 8'h00, 4'hF);
        check(name, rd, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        rdchk(`IDX_PORT_DIRECTION, 8'h3F, "direction");
        rdchk(`IDX_OPTION, 8'hFF, "option");
        rdchk(`IDX_PULLUP_ENABLE, 8'h00, "pullup enable");
        rdchk(`IDX_CHANGE_INT_MASK, 8'h00, "change mask");
        rdchk(`IDX_INTERRUPT_CONTROL, 8'h00, "interrupt control");
        rdchk(8'h10, 8'h00, "unmapped");
        check("oe after reset", {2'b00, pin_oe}, 8'h00);
        ext_val <= 6'h3F;
        tick(3);
        rdchk(`IDX_PORT_PIN_DATA, 8'h28, "analog pins");
        wr(`IDX_ANALOG_SELECT, 8'h00);
        tick(2);
        rdchk(`IDX_PORT_PIN_DATA, 8'h3F, "pin levels");
        wr(`IDX_CONFIG, 8'h01);
        tick(2);
        rdchk(`IDX_PORT_PIN_DATA, 8'h37, "reset pin");
        wr(`IDX_CONFIG, 8'h00);
        ext_val <= 6'h15;
        tick(3);
        bus(1'b1, `IDX_PORT_PIN_DATA, 8'hFF, 4'h0);
        wr(`IDX_PORT_DIRECTION, 8'h00);
        check("latch from pins", {2'b00, pin_out & pin_oe}, 8'h15);
        check("oe all out", {2'b00, pin_oe}, 8'h37);
        rdchk(`IDX_PORT_DIRECTION, 8'h08, "direction bit 3");
        wr(`IDX_PORT_PIN_DATA, 8'h2A);
        check("latch write", {2'b00, pin_out & pin_oe}, 8'h22);
        tick(2);
        rdchk(`IDX_PORT_PIN_DATA, 8'h22, "driven pins");
        wr(`IDX_PORT_DIRECTION, 8'h3F);
        wr(`IDX_PULLUP_ENABLE, 8'h3F);
        check("pullups global off", {2'b00, pin_pu}, 8'h00);
        wr(`IDX_OPTION, 8'h7F);
        check("pullups on", {2'b00, pin_pu}, 8'h37);
        wr(`IDX_PORT_DIRECTION, 8'h3E);
        check("pullup off on output", {2'b00, pin_pu}, 8'h36);
        wr(`IDX_PULLUP_ENABLE, 8'h05);
        check("pullup per pin", {2'b00, pin_pu}, 8'h04);
        wr(`IDX_PORT_DIRECTION, 8'h3F);
        tick(2);
        rdchk(`IDX_PORT_PIN_DATA, 8'h15, "snapshot");
        wr(`IDX_CHANGE_INT_MASK, 8'h01);
        wr(`IDX_INTERRUPT_CONTROL, 8'h08);
        check("no change irq", {7'h00, irq}, 8'h00);
        ext_val <= 6'h14;
        for (int n = 0; n < 10 && irq !== 1'b1; n++) begin
            @(posedge clk_i);
        end
        check("change irq", {7'h00, irq}, 8'h01);
        rdchk(`IDX_INTERRUPT_CONTROL, 8'h09, "change flag");
        rdchk(`IDX_PORT_PIN_DATA, 8'h14, "new snapshot");
        wr(`IDX_INTERRUPT_CONTROL, 8'h08);
        tick(3);
        check("irq cleared", {7'h00, irq}, 8'h00);
        ext_val <= 6'h16;
        tick(8);
        check("unwatched pin", {7'h00, irq}, 8'h00);
        wr(`IDX_ANALOG_SELECT, 8'h01);
        ext_val <= 6'h17;
        tick(8);
        rdchk(`IDX_INTERRUPT_CONTROL, 8'h08, "analog no change");
        periph <= {6'h20, 6'h20, 6'h20};
        tick(2);
        check("peripheral drive", {2'b00, pin_oe & pin_out}, 8'h20);
        rdchk(`IDX_PORT_PIN_DATA, 8'h16, "peripheral pin");
        check("peripheral input", {2'b00, periph_pin}, 8'h36);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
